/* acs_pkg.sv */
// Constants and types for the downstream port access control checks.
package acs_pkg;
  localparam int ACS_TAG_W = 8;
  localparam int ACS_BUS_W = 8;
  localparam int ACS_PORT_W = 4;
  localparam int ACS_NPORTS = 16;
  localparam int ACS_LVL_W = 3;
  localparam logic [ACS_LVL_W-1:0] ACS_LVL_NONE = 3'h0;
  localparam logic [ACS_LVL_W-1:0] ACS_LVL_PEER = 3'h1;
  localparam logic [ACS_LVL_W-1:0] ACS_LVL_UF = 3'h2;
  localparam logic [ACS_LVL_W-1:0] ACS_LVL_TB = 3'h3;
  localparam logic [ACS_LVL_W-1:0] ACS_LVL_SV = 3'h4;
  // Address type field values of untranslated and translated memory requests.
  localparam logic [1:0] ACS_AT_UNTRANS = 2'h0;
  localparam logic [1:0] ACS_AT_TRANS = 2'h2;
  // Bit positions of the check enables in the control word.
  localparam int ACS_EN_SV = 0;
  localparam int ACS_EN_TB = 1;
  localparam int ACS_EN_RR = 2;
  localparam int ACS_EN_CR = 3;
  localparam int ACS_EN_UF = 4;
  localparam int ACS_EN_EC = 5;
  localparam int ACS_EN_DT = 6;
  localparam int ACS_EN_W = 7;
  localparam logic [ACS_EN_W-1:0] ACS_EN_RESET = 7'h00;

  typedef enum logic [1:0] {
    ACS_ACT_PASS = 2'b00,
    ACS_ACT_REDIRECT = 2'b01,
    ACS_ACT_DROP = 2'b10
  } acs_action_e;

  typedef enum logic {
    ACS_ST_EMPTY = 1'b0,
    ACS_ST_FULL = 1'b1
  } acs_state_e;
endpackage

/* acs_check_unit.sv */
// One access check: fires when enabled, applicable and failing.
`timescale 1ns/1ps
`default_nettype none
module acs_check_unit
  import acs_pkg::*;
#(
  parameter logic [ACS_LVL_W-1:0] LEVEL = ACS_LVL_PEER
) (
  input wire logic en_in,
  input wire logic applies_in,
  input wire logic fail_in,
  output logic hit_out,
  output logic [ACS_LVL_W-1:0] level_out
);
  assign hit_out = en_in & applies_in & fail_in;
  assign level_out = hit_out ? LEVEL : ACS_LVL_NONE;
endmodule
`default_nettype wire

/* acs_port_check.sv */
// Access control decision stage for one downstream switch port.
`timescale 1ns/1ps
`default_nettype none
module acs_port_check
  import acs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic port_is_dsp_in,
  input wire logic [ACS_EN_W-1:0] acs_enable_in,
  input wire logic [ACS_BUS_W-1:0] sec_bus_in,
  input wire logic [ACS_BUS_W-1:0] sub_bus_in,
  input wire logic [ACS_NPORTS-1:0] egress_block_in,
  input wire logic tlp_valid_in,
  output logic tlp_ready_out,
  input wire logic [ACS_TAG_W-1:0] tlp_tag_in,
  input wire logic tlp_from_link_in,
  input wire logic tlp_is_req_in,
  input wire logic tlp_is_cpl_in,
  input wire logic tlp_is_mem_in,
  input wire logic tlp_posted_in,
  input wire logic tlp_relaxed_in,
  input wire logic [1:0] tlp_at_in,
  input wire logic [ACS_BUS_W-1:0] tlp_req_bus_in,
  input wire logic tlp_to_own_in,
  input wire logic tlp_to_peer_in,
  input wire logic [ACS_PORT_W-1:0] tlp_dest_port_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [ACS_TAG_W-1:0] out_tag_out,
  output acs_action_e out_action_out,
  output logic out_abort_cpl_out,
  output logic out_posted_out,
  output logic [ACS_LVL_W-1:0] out_level_out
);
  acs_state_e state_reg;
  acs_state_e state_next;
  logic take;
  logic checked;
  logic is_peer;
  logic sv_fail;
  logic [6:0] hit;
  logic [ACS_LVL_W-1:0] lvl [7];
  logic dt_pass;
  acs_action_e act_next;
  logic [ACS_LVL_W-1:0] level_next;

  // A single in-order stage keeps every packet, redirected or not, behind
  // those taken before it, so no completion can pass an earlier posted one.
  assign tlp_ready_out = (state_reg == ACS_ST_EMPTY) || out_ready_in;
  assign take = tlp_valid_in && tlp_ready_out;
  assign out_valid_out = (state_reg == ACS_ST_FULL);

  // Checking happens only on a downstream switch port for link traffic.
  assign checked = port_is_dsp_in && tlp_from_link_in;
  // Aiming at the own egress link never counts as peer traffic.
  assign is_peer = tlp_to_peer_in && !tlp_to_own_in;
  assign sv_fail = (tlp_req_bus_in < sec_bus_in) ||
                   (tlp_req_bus_in > sub_bus_in);

  acs_check_unit #(.LEVEL(ACS_LVL_SV)) u_sv (
    .en_in(checked && acs_enable_in[ACS_EN_SV]),
    .applies_in(tlp_is_req_in),
    .fail_in(sv_fail),
    .hit_out(hit[0]),
    .level_out(lvl[0])
  );
  acs_check_unit #(.LEVEL(ACS_LVL_TB)) u_tb (
    .en_in(checked && acs_enable_in[ACS_EN_TB]),
    .applies_in(tlp_is_req_in && tlp_is_mem_in),
    .fail_in(tlp_at_in != ACS_AT_UNTRANS),
    .hit_out(hit[1]),
    .level_out(lvl[1])
  );
  acs_check_unit #(.LEVEL(ACS_LVL_UF)) u_uf (
    .en_in(checked && acs_enable_in[ACS_EN_UF]),
    .applies_in(tlp_is_req_in || tlp_is_cpl_in),
    .fail_in(tlp_to_own_in),
    .hit_out(hit[2]),
    .level_out(lvl[2])
  );
  acs_check_unit #(.LEVEL(ACS_LVL_PEER)) u_rr (
    .en_in(checked && acs_enable_in[ACS_EN_RR]),
    .applies_in(tlp_is_req_in && is_peer),
    .fail_in(1'b1),
    .hit_out(hit[3]),
    .level_out(lvl[3])
  );
  acs_check_unit #(.LEVEL(ACS_LVL_PEER)) u_ec (
    .en_in(checked && acs_enable_in[ACS_EN_EC]),
    .applies_in(tlp_is_req_in && is_peer),
    .fail_in(egress_block_in[tlp_dest_port_in]),
    .hit_out(hit[4]),
    .level_out(lvl[4])
  );
  acs_check_unit #(.LEVEL(ACS_LVL_PEER)) u_dt (
    .en_in(checked && acs_enable_in[ACS_EN_DT]),
    .applies_in(tlp_is_req_in && tlp_is_mem_in && is_peer),
    .fail_in(tlp_at_in == ACS_AT_TRANS),
    .hit_out(hit[5]),
    .level_out(lvl[5])
  );
  acs_check_unit #(.LEVEL(ACS_LVL_PEER)) u_cr (
    .en_in(checked && acs_enable_in[ACS_EN_CR]),
    .applies_in(tlp_is_cpl_in && is_peer && !tlp_relaxed_in),
    .fail_in(1'b1),
    .hit_out(hit[6]),
    .level_out(lvl[6])
  );

  // A translated peer memory request under direct translated goes straight
  // to its peer, overriding egress control and request redirect.
  assign dt_pass = hit[5];

  // Only the highest failing check acts; lower ones are ignored.
  always_comb begin
    act_next = ACS_ACT_PASS;
    level_next = ACS_LVL_NONE;
    if (hit[0]) begin
      act_next = ACS_ACT_DROP;
      level_next = lvl[0];
    end else if (hit[1]) begin
      act_next = ACS_ACT_DROP;
      level_next = lvl[1];
    end else if (hit[2]) begin
      act_next = ACS_ACT_REDIRECT;
      level_next = lvl[2];
    end else if (dt_pass) begin
      act_next = ACS_ACT_PASS;
      level_next = lvl[5];
    end else if (hit[4]) begin
      act_next = ACS_ACT_DROP;
      level_next = lvl[4];
    end else if (hit[3]) begin
      act_next = ACS_ACT_REDIRECT;
      level_next = lvl[3];
    end else if (hit[6]) begin
      act_next = ACS_ACT_REDIRECT;
      level_next = lvl[6];
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ACS_ST_EMPTY: begin
        if (take) begin
          state_next = ACS_ST_FULL;
        end
      end
      ACS_ST_FULL: begin
        if (out_ready_in && !take) begin
          state_next = ACS_ST_EMPTY;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= ACS_ST_EMPTY;
    end else begin
      state_reg <= state_next;
    end
  end

  // The tag passes through untouched, so the packet body is not altered.
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      out_tag_out <= '0;
      out_action_out <= ACS_ACT_PASS;
      out_abort_cpl_out <= 1'b0;
      out_posted_out <= 1'b0;
      out_level_out <= ACS_LVL_NONE;
    end else if (take) begin
      out_tag_out <= tlp_tag_in;
      out_action_out <= act_next;
      out_abort_cpl_out <= (act_next == ACS_ACT_DROP) && tlp_is_req_in
                           && !tlp_posted_in;
      out_posted_out <= tlp_posted_in;
      out_level_out <= level_next;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);

  sequence s_take;
    tlp_valid_in && tlp_ready_out;
  endsequence

  sequence s_checked_req;
    s_take ##0 (checked && tlp_is_req_in);
  endsequence

  sequence s_stall;
    out_valid_out && !out_ready_in;
  endsequence

  sequence s_checked_peer_req;
    s_checked_req ##0 is_peer;
  endsequence

  chk_sv_drop: assert property (
    s_checked_req ##0 (acs_enable_in[ACS_EN_SV] && sv_fail)
    |=> out_valid_out && out_action_out == ACS_ACT_DROP
        && out_level_out == ACS_LVL_SV)
    else $error("source validation failure not dropped");

  chk_tb_drop: assert property (
    s_checked_req ##0 (tlp_is_mem_in && acs_enable_in[ACS_EN_TB]
      && tlp_at_in != ACS_AT_UNTRANS && !hit[0])
    |=> out_action_out == ACS_ACT_DROP && out_level_out == ACS_LVL_TB)
    else $error("translated request not blocked");

  chk_uf_redirect: assert property (
    s_take ##0 (checked && tlp_to_own_in && acs_enable_in[ACS_EN_UF]
      && (tlp_is_req_in || tlp_is_cpl_in) && !hit[0] && !hit[1])
    |=> out_action_out == ACS_ACT_REDIRECT
        && out_level_out == ACS_LVL_UF)
    else $error("own egress packet not sent to root");

  chk_rr_redirect: assert property (
    s_checked_req ##0 (is_peer && acs_enable_in[ACS_EN_RR]
      && hit[2:0] == 3'h0 && !hit[4] && !hit[5])
    |=> out_action_out == ACS_ACT_REDIRECT)
    else $error("peer request not redirected");

  chk_cr_redirect: assert property (
    s_take ##0 (checked && tlp_is_cpl_in && is_peer && !tlp_relaxed_in
      && acs_enable_in[ACS_EN_CR] && !hit[2])
    |=> out_action_out == ACS_ACT_REDIRECT
        && out_level_out == ACS_LVL_PEER)
    else $error("strict completion not redirected");

  chk_down_bypass: assert property (
    s_take ##0 !tlp_from_link_in
    |=> out_action_out == ACS_ACT_PASS && out_level_out == ACS_LVL_NONE)
    else $error("downstream packet was checked");

  chk_nondsp_bypass: assert property (
    s_take ##0 !port_is_dsp_in |=> out_action_out == ACS_ACT_PASS)
    else $error("non downstream port applied a check");

  chk_tag_kept: assert property (
    s_take |=> out_valid_out && out_tag_out == $past(tlp_tag_in))
    else $error("tag changed or packet lost");

  chk_order_hold: assert property (
    s_stall |=> out_valid_out && $stable(out_tag_out)
                && $stable(out_action_out) && !$past(tlp_ready_out))
    else $error("stalled packet overtaken");

  chk_abort_only_drop: assert property (
    out_valid_out && out_abort_cpl_out
    |-> out_action_out == ACS_ACT_DROP)
    else $error("abort completion without drop");

  // Lowest level checks, abort generation and untouched clean traffic.
  chk_ec_drop: assert property (
    s_checked_peer_req ##0 (acs_enable_in[ACS_EN_EC]
      && egress_block_in[tlp_dest_port_in] && hit[2:0] == 3'h0
      && !hit[5])
    |=> out_action_out == ACS_ACT_DROP
        && out_level_out == ACS_LVL_PEER)
    else $error("blocked peer request not dropped");

  chk_dt_direct: assert property (
    s_checked_peer_req ##0 (tlp_is_mem_in && acs_enable_in[ACS_EN_DT]
      && tlp_at_in == ACS_AT_TRANS && hit[2:0] == 3'h0)
    |=> out_action_out == ACS_ACT_PASS
        && out_level_out == ACS_LVL_PEER)
    else $error("translated peer request not sent direct");

  chk_abort_set: assert property (
    s_checked_req ##0 (acs_enable_in[ACS_EN_SV] && sv_fail
      && !tlp_posted_in)
    |=> out_abort_cpl_out)
    else $error("dropped request lacks abort completion");

  chk_uf_off_pass: assert property (
    s_take ##0 (checked && tlp_to_own_in && !acs_enable_in[ACS_EN_UF]
      && !hit[0] && !hit[1])
    |=> out_action_out == ACS_ACT_PASS)
    else $error("disabled upstream forwarding acted");

  chk_clean_pass: assert property (
    s_take ##0 (hit == 7'h00)
    |=> out_action_out == ACS_ACT_PASS && out_level_out == ACS_LVL_NONE
        && out_posted_out == $past(tlp_posted_in))
    else $error("clean packet altered");

  chk_cpl_no_abort: assert property (
    s_take ##0 (tlp_is_cpl_in && !tlp_is_req_in)
    |=> !out_abort_cpl_out && out_action_out != ACS_ACT_DROP)
    else $error("completion dropped or aborted");

  chk_ready_empty: assert property (
    !out_valid_out |-> tlp_ready_out)
    else $error("empty stage refused a packet");
endmodule
`default_nettype wire

/* acs_link_partner.sv */
// Behavioural link partner offering received packet descriptors.
`timescale 1ns/1ps
`default_nettype none
module acs_link_partner (
  input wire logic clk_in,
  input wire logic tlp_ready_in,
  output logic tlp_valid_out,
  output logic [29:0] desc_out
);
  initial begin
    tlp_valid_out = 1'b0;
    desc_out = 30'h0;
  end
  // Offers a descriptor after an edge and holds it until the taking edge.
  task automatic send(input logic [29:0] d);
    logic rdy;
    #1;
    tlp_valid_out = 1'b1;
    desc_out = d;
    rdy = 1'b0;
    while (!rdy) begin
      @(negedge clk_in);
      rdy = (tlp_ready_in === 1'b1);
      @(posedge clk_in);
    end
  endtask
  // Released lines show the inverse of the last value; a second release in a row brings back a stale copy.
  task automatic idle();
    #1;
    tlp_valid_out = 1'b0;
    desc_out = ~desc_out;
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the access control decision stage.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import acs_pkg::*;
();
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic dsp = 1'b1;
  logic [ACS_EN_W-1:0] en = ACS_EN_RESET;
  logic [ACS_NPORTS-1:0] eblk = 16'h0;
  logic out_ready_in = 1'b1;
  logic stall = 1'b0;
  logic [1:0] cyc = 2'h0;
  logic tv, tr, ov, oab, opo;
  logic [29:0] desc;
  logic [7:0] otag;
  acs_action_e oact;
  logic [2:0] olvl;
  logic [14:0] seen;
  logic [14:0] expq[$];
  int fails = 0;
  int cmp_count = 0;
  assign seen = {otag, oact, olvl, oab, opo};
  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 2'h1;
    out_ready_in <= #1 !stall || (cyc == 2'h3);
  end
  acs_link_partner u_acs_link_partner (
    .clk_in(clk_sys_in), .tlp_ready_in(tr),
    .tlp_valid_out(tv), .desc_out(desc));
  acs_port_check u_acs_port_check (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .port_is_dsp_in(dsp), .acs_enable_in(en),
    .sec_bus_in(8'h10), .sub_bus_in(8'h1f),
    .egress_block_in(eblk), .tlp_valid_in(tv),
    .tlp_ready_out(tr), .tlp_tag_in(desc[29:22]),
    .tlp_from_link_in(desc[21]), .tlp_is_req_in(desc[20]),
    .tlp_is_cpl_in(desc[19]), .tlp_is_mem_in(desc[18]),
    .tlp_posted_in(desc[17]), .tlp_relaxed_in(desc[16]),
    .tlp_at_in(desc[15:14]), .tlp_req_bus_in(desc[13:6]),
    .tlp_to_own_in(desc[5]), .tlp_to_peer_in(desc[4]),
    .tlp_dest_port_in(desc[3:0]), .out_valid_out(ov),
    .out_ready_in(out_ready_in), .out_tag_out(otag),
    .out_action_out(oact), .out_abort_cpl_out(oab),
    .out_posted_out(opo), .out_level_out(olvl));
  task automatic check(input logic [14:0] got, input logic [14:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(negedge clk_sys_in) begin
    if (ov === 1'b1 && out_ready_in === 1'b1) begin
      if (expq.size() == 0) check(seen, 15'h7fff);
      else check(seen, expq.pop_front());
    end
  end
  function automatic logic [29:0] rq(input logic [7:0] t,
      input logic m, p, input logic [1:0] at, input logic [7:0] b,
      input logic o, pr, input logic [3:0] d);
    return {t, 3'b110, m, p, 1'b0, at, b, o, pr, d};
  endfunction
  function automatic logic [29:0] cp(input logic [7:0] t,
      input logic rx, input logic [7:0] b, input logic o, pr);
    return {t, 3'b101, 2'b00, rx, 2'h0, b, o, pr, 4'h3};
  endfunction
  // Queues the result the rules demand, then offers the descriptor.
  task automatic put(input logic [29:0] d, input logic [1:0] a,
      input logic [2:0] l);
    expq.push_back({d[29:22], a, l, a == ACS_ACT_DROP && d[20]
      && !d[17], d[17]});
    u_acs_link_partner.send(d);
  endtask
  task automatic drain();
    u_acs_link_partner.idle();
    repeat (40) if (expq.size() != 0) @(posedge clk_sys_in);
    check(15'(expq.size()), 15'h0);
  endtask
  task automatic cfg(input logic [6:0] e, input logic [15:0] b,
      input logic s);
    // Withdraw the last offer first, or it would be taken a second time.
    u_acs_link_partner.idle();
    @(posedge clk_sys_in);
    #1;
    en = e;
    eblk = b;
    stall = s;
  endtask
  task automatic t_req_prio(input logic s);
    cfg(7'h7f, 16'hffff, s);
    put(rq(1, 1, 0, 2'h2, 8'h05, 1, 0, 0), ACS_ACT_DROP, 4);
    put(rq(2, 1, 1, 2'h2, 8'h20, 0, 1, 3), ACS_ACT_DROP, 4);
    put(rq(3, 1, 0, 2'h2, 8'h12, 1, 0, 0), ACS_ACT_DROP, 3);
    put(rq(4, 1, 0, 2'h0, 8'h12, 1, 1, 3), ACS_ACT_REDIRECT, 2);
    put(rq(5, 0, 0, 2'h2, 8'h1f, 0, 1, 3), ACS_ACT_DROP, 1);
    put(rq(6, 1, 1, 2'h0, 8'h10, 0, 1, 3), ACS_ACT_DROP, 1);
    drain();
  endtask
  task automatic t_cpl_prio();
    cfg(7'h7f, 16'h0000, 1'b0);
    put(cp(7, 0, 8'h05, 1, 0), ACS_ACT_REDIRECT, 2);
    put(cp(8, 0, 8'h05, 0, 1), ACS_ACT_REDIRECT, 1);
    put(cp(9, 1, 8'h05, 0, 1), ACS_ACT_PASS, 0);
    put(rq(10, 0, 0, 2'h0, 8'h10, 0, 1, 3), ACS_ACT_REDIRECT, 1);
    put(rq(11, 1, 0, 2'h0, 8'h10, 0, 0, 0), ACS_ACT_PASS, 0);
    drain();
  endtask
  task automatic t_direct();
    cfg(7'h7d, 16'h0020, 1'b0);
    put(rq(12, 1, 1, 2'h2, 8'h10, 0, 1, 5), ACS_ACT_PASS, 1);
    put(rq(13, 1, 1, 2'h0, 8'h10, 0, 1, 5), ACS_ACT_DROP, 1);
    drain();
    cfg(7'h6f, 16'hffff, 1'b0);
    put(rq(14, 1, 0, 2'h0, 8'h12, 1, 0, 0), ACS_ACT_PASS, 0);
    cfg(7'h00, 16'hffff, 1'b0);
    put(rq(15, 1, 0, 2'h2, 8'h05, 0, 1, 3), ACS_ACT_PASS, 0);
    drain();
  endtask
  task automatic t_bypass();
    cfg(7'h7f, 16'hffff, 1'b0);
    put(rq(16, 1, 0, 2'h2, 8'h05, 1, 0, 0) & ~30'h200000,
      ACS_ACT_PASS, 0);
    drain();
    #1;
    dsp = 1'b0;
    put(rq(17, 1, 0, 2'h2, 8'h05, 0, 1, 3), ACS_ACT_PASS, 0);
    drain();
    #1;
    dsp = 1'b1;
  endtask
  task automatic finish_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #12;
    check(15'({tr, ov}), 15'h2);
    @(posedge clk_sys_in);
    #1;
    reset_in = 1'b0;
    t_req_prio(1'b0);
    t_cpl_prio();
    t_direct();
    t_bypass();
    t_req_prio(1'b1);
    finish_test();
  end
  initial begin
    #20000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
